//--- dcp_pkg.sv
/*
 * Shared constants for the digital potentiometer control-pin logic:
 * serial word layout, command codes, reset values and timing.
 * Assumes a single 200 MHz system clock.
 */
`default_nettype none

package dcp_pkg;

   // Serial word layout
   localparam int WORD_W    = 24;
   localparam int CMD_MSB   = 23;
   localparam int CMD_LSB   = 20;
   localparam int ADDR_MSB  = 19;
   localparam int ADDR_LSB  = 16;
   localparam int DATA_W    = 10;
   localparam int CMD_W     = CMD_MSB - CMD_LSB + 1;
   localparam int ADDR_W    = ADDR_MSB - ADDR_LSB + 1;
   localparam int PAD_W     = WORD_W - CMD_W - ADDR_W - DATA_W;

   // Wiper addresses
   localparam logic [ADDR_W-1:0] ADDR_FIRST_WIPER  = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_SECOND_WIPER = 4'h1;

   // Factory default of the store and the wiper
   localparam logic [DATA_W-1:0] MIDSCALE = 10'h200;

   // Timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int OP_TIME_NS    = 1000;
   localparam int OP_CYCLES     = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W         = 16;

   // Command codes
   typedef enum logic [CMD_W-1:0] {
      CMD_NO_OPERATION          = 4'h0,
      CMD_RESTORE_ONE           = 4'h1,
      CMD_STORE_ONE             = 4'h2,
      CMD_WRITE_NV              = 4'h3,
      CMD_RESTORE_COMMAND_EIGHT = 4'h8,
      CMD_READ_NV               = 4'h9,
      CMD_READ_WIPER            = 4'hA,
      CMD_WRITE_WIPER           = 4'hB
   } dcp_cmd_t;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_BUSY = 1'b1
   } dcp_state_t;

endpackage : dcp_pkg

`default_nettype wire

//--- dcp_shifter.sv
/*
 * Serial input shifter: samples the host serial clock, shifts data in
 * MSB first on its rising edges while select is low, and flags the word
 * when select returns high. The same register drives the serial output.
 * Assumes serial pins are synchronous to the system clock.
 */
`timescale 1ns/1ps
`default_nettype none

module dcp_shifter (
   // System
   input  wire logic                       clock,
   input  wire logic                       rst,
   // Serial pins
   input  wire logic                       serial_clk,
   input  wire logic                       sdi,
   input  wire logic                       cs_n,
   output logic                            sdo,
   // Parallel side
   input  wire logic                       load,
   input  wire logic [dcp_pkg::WORD_W-1:0] load_word,
   output logic [dcp_pkg::WORD_W-1:0]      word,
   output logic                            word_valid
);

   logic                       sclk_q, sclk_d;
   logic                       cs_n_q, cs_n_d;
   logic [dcp_pkg::WORD_W-1:0] shift_q, shift_d;
   logic                       valid_q, valid_d;

   always_comb begin
      sclk_d  = serial_clk;
      cs_n_d  = cs_n;
      valid_d = cs_n & ~cs_n_q;
      shift_d = shift_q;
      if (load) begin
         shift_d = load_word;
      end else if (serial_clk & ~sclk_q & ~cs_n) begin
         shift_d = {shift_q[dcp_pkg::WORD_W-2:0], sdi};
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         sclk_q  <= 1'b0;
         cs_n_q  <= 1'b1;
         valid_q <= 1'b0;
         shift_q <= '0;
      end else begin
         sclk_q  <= sclk_d;
         cs_n_q  <= cs_n_d;
         valid_q <= valid_d;
         shift_q <= shift_d;
      end
   end

   assign word       = shift_q;
   assign word_valid = valid_q;
   assign sdo        = shift_q[dcp_pkg::WORD_W-1];

endmodule : dcp_shifter

`default_nettype wire

//--- dcp_control_pins.sv
/*
 * Control-pin logic of a dual-channel nonvolatile digital potentiometer:
 * serial command execution, write protect, preset reload and ready.
 * Assumes all pins are synchronous to the 200 MHz clock; the host
 * waits for ready before the next frame or preset.
 */
// Notes on behaviour
// - Address 0x1 selects second wiper setting.
// - Write protect low blocks changes, preset and restores 1, 8 excepted.
// - Restore commands 1, 8 work under protect.
// - Preset copies nonvolatile store into wiper.
// - Preset acts on its rising edge.
// - Unwritten store reloads midscale 512.
// - Select low; word executes on select rising.
// - Ready marks end of 2,3,8,9,10, preset.
// - Address 0x0 selects first wiper setting.
`timescale 1ns/1ps
`default_nettype none

module dcp_control_pins #(
   parameter int CHANNELS  = 2,
   parameter int OP_CYCLES = dcp_pkg::OP_CYCLES
) (
   // System
   input  wire logic                         clock,
   input  wire logic                         rst,
   // Serial port
   input  wire logic                         serial_clk,
   input  wire logic                         sdi,
   input  wire logic                         cs_n,
   output logic                              sdo,
   // Control pins
   input  wire logic                         write_protect_n,
   input  wire logic                         preset_strobe_n,
   // Ready, open drain
   output logic                              rdy_o,
   output logic                              rdy_oe,
   // Wiper settings
   output logic [CHANNELS-1:0][dcp_pkg::DATA_W-1:0] wiper_setting_register
);

   localparam int DW = dcp_pkg::DATA_W;
   localparam int CW = dcp_pkg::CNT_W;

   // Refuse sizes the logic cannot serve
   if (CHANNELS != 2) begin : g_bad_channels
      $error("CHANNELS must be 2");
   end
   if (OP_CYCLES < 1 || OP_CYCLES >= (1 << CW)) begin : g_bad_cycles
      $error("OP_CYCLES out of range");
   end

   // Wiper address to channel index; valid only for mapped addresses
   function automatic logic addr_valid(input logic [dcp_pkg::ADDR_W-1:0] a);
      addr_valid = (a == dcp_pkg::ADDR_FIRST_WIPER) || (a == dcp_pkg::ADDR_SECOND_WIPER);
   endfunction : addr_valid

   function automatic logic addr_chan(input logic [dcp_pkg::ADDR_W-1:0] a);
      addr_chan = (a == dcp_pkg::ADDR_SECOND_WIPER);
   endfunction : addr_chan

   logic [dcp_pkg::WORD_W-1:0] word;
   logic                       word_valid;
   logic                       load;
   logic [dcp_pkg::WORD_W-1:0] load_word;

   dcp_shifter u_shifter (
      .clock      (clock),
      .rst        (rst),
      .serial_clk (serial_clk),
      .sdi        (sdi),
      .cs_n       (cs_n),
      .sdo        (sdo),
      .load       (load),
      .load_word  (load_word),
      .word       (word),
      .word_valid (word_valid)
   );

   dcp_pkg::dcp_state_t           state_q, state_d;
   logic [dcp_pkg::CNT_W-1:0]     cnt_q, cnt_d;
   logic [CHANNELS-1:0][DW-1:0]   wiper_q, wiper_d;
   logic [CHANNELS-1:0][DW-1:0]   nv_q, nv_d;
   logic                          pr_q, pr_d;

   logic [dcp_pkg::CMD_W-1:0]     cmd;
   logic [dcp_pkg::ADDR_W-1:0]    addr;
   logic [DW-1:0]                 data;
   logic                          ch;
   logic                          protect;
   logic                          pr_rise;
   logic                          go_busy;

   assign cmd     = word[dcp_pkg::CMD_MSB:dcp_pkg::CMD_LSB];
   assign addr    = word[dcp_pkg::ADDR_MSB:dcp_pkg::ADDR_LSB];
   assign data    = word[DW-1:0];
   assign ch      = addr_chan(addr);
   assign protect = ~write_protect_n;
   assign pr_rise = preset_strobe_n & ~pr_q;

   always_comb begin
      state_d   = state_q;
      cnt_d     = cnt_q;
      wiper_d   = wiper_q;
      nv_d      = nv_q;
      pr_d      = preset_strobe_n;
      load      = 1'b0;
      load_word = '0;
      go_busy   = 1'b0;
      case (state_q)
         dcp_pkg::ST_IDLE: begin
            if (pr_rise) begin
               wiper_d = nv_q;
               go_busy = 1'b1;
            end else if (word_valid) begin
               case (cmd)
                  dcp_pkg::CMD_RESTORE_ONE: begin
                     if (addr_valid(addr)) begin
                        wiper_d[ch] = nv_q[ch];
                     end
                  end
                  dcp_pkg::CMD_STORE_ONE: begin
                     if (addr_valid(addr) && !protect) begin
                        nv_d[ch] = wiper_q[ch];
                     end
                     go_busy = 1'b1;
                  end
                  dcp_pkg::CMD_WRITE_NV: begin
                     if (addr_valid(addr) && !protect) begin
                        nv_d[ch] = data;
                     end
                     go_busy = 1'b1;
                  end
                  dcp_pkg::CMD_RESTORE_COMMAND_EIGHT: begin
                     wiper_d = nv_q;
                     go_busy = 1'b1;
                  end
                  dcp_pkg::CMD_READ_NV: begin
                     load      = addr_valid(addr);
                     load_word = {cmd, addr, {dcp_pkg::PAD_W{1'b0}}, nv_q[ch]};
                     go_busy   = 1'b1;
                  end
                  dcp_pkg::CMD_READ_WIPER: begin
                     load      = addr_valid(addr);
                     load_word = {cmd, addr, {dcp_pkg::PAD_W{1'b0}}, wiper_q[ch]};
                     go_busy   = 1'b1;
                  end
                  dcp_pkg::CMD_WRITE_WIPER: begin
                     if (addr_valid(addr) && !protect) begin
                        wiper_d[ch] = data;
                     end
                  end
                  default: begin
                  end
               endcase
            end
            if (go_busy) begin
               state_d = dcp_pkg::ST_BUSY;
               cnt_d   = CW'(OP_CYCLES - 1);
            end
         end
         dcp_pkg::ST_BUSY: begin
            // Frames and strobes during busy are dropped
            if (cnt_q == '0) begin
               state_d = dcp_pkg::ST_IDLE;
            end else begin
               cnt_d = cnt_q - CW'(1);
            end
         end
         default: begin
            state_d = dcp_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= dcp_pkg::ST_IDLE;
         cnt_q   <= '0;
         wiper_q <= {CHANNELS{dcp_pkg::MIDSCALE}};
         nv_q    <= {CHANNELS{dcp_pkg::MIDSCALE}};
         pr_q    <= 1'b1;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         wiper_q <= wiper_d;
         nv_q    <= nv_d;
         pr_q    <= pr_d;
      end
   end

   // Busy pulls the line low; released means ready
   assign rdy_o  = 1'b0;
   assign rdy_oe = (state_q == dcp_pkg::ST_BUSY);
   assign wiper_setting_register = wiper_q;

   // Checks
   property p_preset_reload;
      @(posedge clock) disable iff (rst)
      (pr_rise && state_q == dcp_pkg::ST_IDLE) |=> (wiper_q == $past(nv_q)) && rdy_oe;
   endproperty
   a_preset_reload: assert property (p_preset_reload) else $error("preset did not reload");

   property p_preset_edge;
      @(posedge clock) disable iff (rst)
      (state_q == dcp_pkg::ST_IDLE && !word_valid && !(preset_strobe_n && !pr_q))
         |=> (wiper_q == $past(wiper_q));
   endproperty
   a_preset_edge: assert property (p_preset_edge) else $error("wiper changed without cause");

   property p_protect_nv;
      @(posedge clock) disable iff (rst)
      !write_protect_n |=> (nv_q == $past(nv_q));
   endproperty
   a_protect_nv: assert property (p_protect_nv) else $error("store changed under protect");

   property p_protect_wiper;
      @(posedge clock) disable iff (rst)
      (!write_protect_n && word_valid && !pr_rise && cmd == dcp_pkg::CMD_WRITE_WIPER)
         |=> (wiper_q == $past(wiper_q));
   endproperty
   a_protect_wiper: assert property (p_protect_wiper) else $error("wiper written under protect");

   property p_restore_all;
      @(posedge clock) disable iff (rst)
      (state_q == dcp_pkg::ST_IDLE && word_valid && !pr_rise
         && cmd == dcp_pkg::CMD_RESTORE_COMMAND_EIGHT) |=> (wiper_q == $past(nv_q));
   endproperty
   a_restore_all: assert property (p_restore_all) else $error("restore eight failed");

   property p_second_wiper;
      @(posedge clock) disable iff (rst)
      (state_q == dcp_pkg::ST_IDLE && word_valid && !pr_rise && write_protect_n
         && cmd == dcp_pkg::CMD_WRITE_WIPER && addr == dcp_pkg::ADDR_SECOND_WIPER)
         |=> (wiper_q[1] == $past(data)) && (wiper_q[0] == $past(wiper_q[0]));
   endproperty
   a_second_wiper: assert property (p_second_wiper) else $error("second wiper not written");

   property p_first_wiper;
      @(posedge clock) disable iff (rst)
      (state_q == dcp_pkg::ST_IDLE && word_valid && !pr_rise && write_protect_n
         && cmd == dcp_pkg::CMD_WRITE_WIPER && addr == dcp_pkg::ADDR_FIRST_WIPER)
         |=> (wiper_q[0] == $past(data)) && (wiper_q[1] == $past(wiper_q[1]));
   endproperty
   a_first_wiper: assert property (p_first_wiper) else $error("first wiper not written");

   property p_select_exec;
      @(posedge clock) disable iff (rst)
      word_valid |-> $past(cs_n, 1) && !$past(cs_n, 2);
   endproperty
   a_select_exec: assert property (p_select_exec) else $error("word without select rise");

   property p_ready_time;
      @(posedge clock) disable iff (rst)
      $rose(rdy_oe) |-> (cnt_q == CW'(OP_CYCLES - 1));
   endproperty
   a_ready_time: assert property (p_ready_time) else $error("busy count wrong");

   property p_ready_end;
      @(posedge clock) disable iff (rst)
      (rdy_oe && cnt_q == '0) |=> !rdy_oe;
   endproperty
   a_ready_end: assert property (p_ready_end) else $error("ready not released");

   property p_midscale;
      @(posedge clock)
      $fell(rst) |-> (nv_q == {CHANNELS{dcp_pkg::MIDSCALE}});
   endproperty
   a_midscale: assert property (p_midscale) else $error("store not midscale");

endmodule : dcp_control_pins

`default_nettype wire

//--- dcp_dummy_guard.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- dcp_host_model.sv
/*
 * Host model for the potentiometer control pins: frames serial words,
 * drives write protect and the preset strobe, captures readback.
 * Assumes all outputs change 1 ns after a rising clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module dcp_host_model (
   // System
   input  wire logic clock,
   // Serial port
   input  wire logic sdo,
   output logic      serial_clk,
   output logic      sdi,
   output logic      cs_n,
   // Control pins
   output logic      write_protect_n,
   output logic      preset_strobe_n
);
   initial begin
      serial_clk      = 1'h0;
      sdi             = 1'h0;
      cs_n            = 1'h1;
      write_protect_n = 1'h1;
      preset_strobe_n = 1'h1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick

   // Select low, 24 bits MSB first; readback sampled before each rise
   task automatic shift_bits(input logic [23:0] w, output logic [23:0] rb);
      cs_n = 1'h0;
      tick(2);
      for (int i = 23; i >= 0; i--) begin
         sdi        = w[i];
         serial_clk = 1'h0;
         tick(2);
         rb[i]      = sdo;
         serial_clk = 1'h1;
         tick(2);
      end
      serial_clk = 1'h0;
      tick(2);
   endtask : shift_bits

   task automatic end_frame();
      cs_n = 1'h1;
      sdi  = ~sdi;
      tick(1);
   endtask : end_frame

   // No-operation word before protect goes back high
   task automatic set_protect(input logic v);
      logic [23:0] rb;
      if (v && !write_protect_n) begin
         shift_bits(24'h000000, rb);
         end_frame();
         tick(2);
      end
      write_protect_n = v;
      tick(1);
   endtask : set_protect

   task automatic preset_level(input logic v);
      preset_strobe_n = v;
      tick(1);
   endtask : preset_level
endmodule : dcp_host_model

`default_nettype wire

//--- test_digipot_control_pins.sv
/*
 * Self-checking bench for the potentiometer control pins.
 * Assumes the host model drives all pins and ready has a pull-up.
 */
`timescale 1ns/1ps
`default_nettype none

module test_digipot_control_pins;
   typedef struct packed {
      logic [3:0]  cmd;
      logic [3:0]  addr;
      logic [9:0]  data;
      logic        wp;
      logic [9:0]  w0;
      logic [9:0]  w1;
      logic        busy;
      logic        rbv;
      logic [23:0] rb;
   } dcp_row_t;

   logic clock, rst, serial_clk, sdi, cs_n, sdo, wp_n, pr_n, rdy_o, rdy_oe;
   logic [1:0][dcp_pkg::DATA_W-1:0] wiper;
   logic [23:0] rb;
   int          fails, n_tests;
   dcp_row_t    rows [14];
   // Open drain with pull-up
   wire logic   rdy_pin = rdy_oe ? rdy_o : 1'h1;

   initial clock = 1'h0;
   always #2.5 clock = ~clock;

   dcp_control_pins #(.OP_CYCLES(4)) i_dut (
      .clock                  (clock),
      .rst                    (rst),
      .serial_clk             (serial_clk),
      .sdi                    (sdi),
      .cs_n                   (cs_n),
      .sdo                    (sdo),
      .write_protect_n        (wp_n),
      .preset_strobe_n        (pr_n),
      .rdy_o                  (rdy_o),
      .rdy_oe                 (rdy_oe),
      .wiper_setting_register (wiper)
   );

   dcp_host_model i_host (
      .clock           (clock),
      .sdo             (sdo),
      .serial_clk      (serial_clk),
      .sdi             (sdi),
      .cs_n            (cs_n),
      .write_protect_n (wp_n),
      .preset_strobe_n (pr_n)
   );

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : give_verdict

   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wait_ready();
      for (int i = 0; i < 100 && rdy_pin !== 1'h1; i++) tick(1);
      if (rdy_pin !== 1'h1) begin
         fails++;
         $display("BAD t=%0t ready never returned", $time);
         give_verdict();
      end
   endtask : wait_ready

   task automatic frame(input logic [3:0] c, input logic [3:0] a, input logic [9:0] d);
      i_host.shift_bits({c, a, 6'h00, d}, rb);
      i_host.end_frame();
   endtask : frame

   task automatic do_reset();
      rst = 1'h1;
      tick(16);
      rst = 1'h0;
      tick(3);
      check(24'(wiper[0]), 24'h000200);
      check(24'(wiper[1]), 24'h000200);
      check(24'(rdy_pin), 24'h000001);
   endtask : do_reset

   initial begin
      rst     = 1'h1;
      fails   = 0;
      n_tests = 0;
      rows = '{
         '{4'hB, 4'h0, 10'h155, 1'h1, 10'h155, 10'h200, 1'h0, 1'h0, 24'h0},
         '{4'hB, 4'h1, 10'h2AA, 1'h1, 10'h155, 10'h2AA, 1'h0, 1'h0, 24'h0},
         '{4'h2, 4'h1, 10'h000, 1'h1, 10'h155, 10'h2AA, 1'h1, 1'h0, 24'h0},
         '{4'h3, 4'h0, 10'h0F0, 1'h1, 10'h155, 10'h2AA, 1'h1, 1'h0, 24'h0},
         '{4'h8, 4'h0, 10'h000, 1'h0, 10'h0F0, 10'h2AA, 1'h1, 1'h0, 24'h0},
         '{4'hB, 4'h0, 10'h011, 1'h1, 10'h011, 10'h2AA, 1'h0, 1'h0, 24'h0},
         '{4'hB, 4'h0, 10'h3FF, 1'h0, 10'h011, 10'h2AA, 1'h0, 1'h0, 24'h0},
         '{4'h3, 4'h0, 10'h3FF, 1'h0, 10'h011, 10'h2AA, 1'h1, 1'h0, 24'h0},
         '{4'h1, 4'h0, 10'h000, 1'h0, 10'h0F0, 10'h2AA, 1'h0, 1'h0, 24'h0},
         '{4'h9, 4'h1, 10'h000, 1'h1, 10'h0F0, 10'h2AA, 1'h1, 1'h0, 24'h0},
         '{4'hA, 4'h0, 10'h000, 1'h1, 10'h0F0, 10'h2AA, 1'h1, 1'h1, 24'h9102AA},
         '{4'h0, 4'h0, 10'h000, 1'h1, 10'h0F0, 10'h2AA, 1'h0, 1'h1, 24'hA000F0},
         '{4'hB, 4'h2, 10'h3FF, 1'h1, 10'h0F0, 10'h2AA, 1'h0, 1'h0, 24'h0},
         '{4'h5, 4'h0, 10'h3FF, 1'h1, 10'h0F0, 10'h2AA, 1'h0, 1'h0, 24'h0}};
      tick(1);
      do_reset();
      $display("test reset done");
      foreach (rows[i]) begin
         i_host.set_protect(rows[i].wp);
         frame(rows[i].cmd, rows[i].addr, rows[i].data);
         tick(3);
         check(24'(rdy_pin), 24'(!rows[i].busy));
         wait_ready();
         check(24'(wiper[0]), 24'(rows[i].w0));
         check(24'(wiper[1]), 24'(rows[i].w1));
         if (rows[i].rbv) check(rb, rows[i].rb);
         $display("test row %0d done", i);
      end
      // Word held until select rises
      i_host.shift_bits(24'hB1_0123, rb);
      tick(6);
      check(24'(wiper[1]), 24'h0002AA);
      i_host.end_frame();
      tick(3);
      check(24'(wiper[1]), 24'h000123);
      $display("test select done");
      // Preset: nothing while low, reload on rise
      i_host.preset_level(1'h0);
      tick(6);
      check(24'(wiper[1]), 24'h000123);
      i_host.preset_level(1'h1);
      tick(2);
      check(24'(rdy_pin), 24'h000000);
      wait_ready();
      check(24'(wiper[1]), 24'h0002AA);
      check(24'(wiper[0]), 24'h0000F0);
      $display("test preset done");
      // Fresh store reloads midscale, even under protect
      do_reset();
      frame(4'hB, 4'h0, 10'h003);
      tick(3);
      check(24'(wiper[0]), 24'h000003);
      i_host.set_protect(1'h0);
      i_host.preset_level(1'h0);
      tick(2);
      i_host.preset_level(1'h1);
      tick(2);
      wait_ready();
      check(24'(wiper[0]), 24'h000200);
      i_host.set_protect(1'h1);
      $display("test midscale done");
      give_verdict();
   end
endmodule : test_digipot_control_pins

`default_nettype wire
